// [design/panel_defs.svh]
`ifndef PANEL_DEFS_SVH
`define PANEL_DEFS_SVH
// =====================================
// widths
`define WORD_W 16
`define BANK_W 2
`define ADDR_W 18
`define VIEW_W 5
`define VIEW_COUNT 17
// number of synchronised level switches and spring-return presses
`define LEVEL_W 27
`define PRESS_W 5
// =====================================
// reset values and step size
`define STEP_SIZE 16'h0001
`define WORD_RST 16'h0000
`define BANK_RST 2'h0
// only the address view lamp is lit out of reset
`define LAMPS_RST 17'h00001
`endif

// [design/panel_pkg.sv]
package panel_pkg;
  // =====================================
  // register selection views, one lamp each
  typedef enum logic [4:0] {
    address_view = 5'h00, mem_data_view = 5'h01, sp2_view = 5'h02, sp3_view = 5'h03,
    ra_view = 5'h04, rb_view = 5'h05, rc_view = 5'h06, rd_view = 5'h07,
    status_view = 5'h08, program_base_view = 5'h09, p_view = 5'h0A, pl_view = 5'h0B,
    dl_view = 5'h0C, data_base_view = 5'h0D, q_view = 5'h0E, s_view = 5'h0F,
    z_view = 5'h10
  } view_type;
  // memory display sequencer
  typedef enum logic [0:0] {
    idle_st = 1'b0,
    wait_read_st = 1'b1
  } mstate_type;
  // whole state of the panel control
  typedef struct packed {
    mstate_type mst;
    view_type view;
    logic [15:0] ptr;
    logic [1:0] abs_bank;
    logic [1:0] prog_bank;
    logic [1:0] stk_bank;
    logic [1:0] dat_bank;
    logic [15:0] mem_data;
    logic bkpt_cause;
    logic halt_req;
    logic reg_wr;
    view_type reg_wr_view;
    logic [15:0] reg_wr_data;
    logic rd_req;
    logic wr_req;
    logic [17:0] addr;
    logic [15:0] wr_data;
    logic [15:0] disp_word;
    logic [1:0] disp_bank;
    logic [16:0] lamps;
    logic bkpt_lamp;
    logic sys_lamp;
    logic run_lamp;
  } panel_state_type;
endpackage

// [design/level_sync.sv]
`timescale 1ns/10ps
// =====================================
// two-stage synchroniser for operator levels
module level_sync #(
  parameter int WIDTH = 27
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // levels
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  // both stages in one state word
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } lsync_type;
  lsync_type r, next_r;
  // first stage feeds only the second
  always_comb begin
    next_r = r;
    next_r.s1 = din;
    next_r.s2 = r.s1;
  end
  // register, frozen while ce low
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end
  assign dout = r.s2;
endmodule // level_sync

// [design/press_pulse.sv]
`timescale 1ns/10ps
// =====================================
// synchronise spring-return presses and make one pulse per press
module press_pulse #(
  parameter int WIDTH = 5
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // raw switches and pulses
  input wire logic [WIDTH-1:0] press,
  output logic [WIDTH-1:0] pulse
);
  // s3 remembers the last synchronised level for the edge
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
  } psync_type;
  psync_type r, next_r;
  // shift chain; s1 is read by s2 alone
  always_comb begin
    next_r = r;
    next_r.s1 = press;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
  end
  // register, frozen while ce low
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end
  assign pulse = ce ? (r.s2 & ~r.s3) : '0;
endmodule // press_pulse

// [design/maintenance_panel_control.sv]
`timescale 1ns/10ps
`include "panel_defs.svh"
module maintenance_panel_control
  import panel_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // operator switches
  input wire logic [15:0] switch_word,
  input wire logic bank_switch_bit_lo,
  input wire logic bank_switch_bit_hi,
  input wire logic [4:0] select_code,
  input wire logic select_press,
  input wire logic load_switch_press,
  input wire logic load_display_press,
  input wire logic mem_display_press,
  input wire logic mem_store_press,
  input wire logic incr_enable,
  input wire logic decr_enable,
  input wire logic read_bkpt_enable,
  input wire logic store_bkpt_enable,
  // lamps
  output logic [16:0] select_lamps,
  output logic [15:0] display_word,
  output logic [1:0] display_bank,
  output logic breakpoint_halt_indicator,
  output logic system_halt_indicator,
  output logic run_indicator,
  // cpu register set
  input wire logic cpu_running,
  input wire logic cpu_halted,
  input wire logic cpu_error_halt,
  input wire logic [15:0] cpu_reg_data,
  output logic [4:0] display_view,
  output logic cpu_halt_req,
  output logic reg_wr,
  output logic [4:0] reg_wr_view,
  output logic [15:0] reg_wr_data,
  // bank registers
  output logic [1:0] program_bank,
  output logic [1:0] stack_bank,
  output logic [1:0] data_bank,
  // panel memory port
  output logic mem_rd_req,
  output logic mem_wr_req,
  output logic [17:0] mem_addr,
  output logic [15:0] mem_wr_data,
  input wire logic mem_rvalid,
  input wire logic [15:0] mem_rdata,
  // memory traffic monitor
  input wire logic mon_rd_valid,
  input wire logic [15:0] mon_rd_data,
  input wire logic mon_wr_valid,
  input wire logic [15:0] mon_wr_data,
  input wire logic [1:0] mon_wr_module
);
  // =====================================
  // synchronised operator inputs
  logic [`LEVEL_W-1:0] lvl; // synchronised levels
  logic [`PRESS_W-1:0] pls; // one-cycle press pulses
  logic [15:0] sw; // switch word
  logic [1:0] sw_bank; // bank switch pair
  logic [4:0] sw_sel; // selection code
  logic inc_en, dec_en, rbk_en, sbk_en;
  logic sel_p, lsw_p, ldisp_p, mdisp_p, mstore_p;
  logic rd_match, wr_match, step_ok;
  logic bkpt_lamp_cause; // helper for checks
  panel_state_type r, next_r;

  // all operator pins come from outside the clock domain
  level_sync #(.WIDTH(`LEVEL_W)) u_lvl (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .din({switch_word, bank_switch_bit_hi, bank_switch_bit_lo, select_code,
          incr_enable, decr_enable, read_bkpt_enable, store_bkpt_enable}),
    .dout(lvl)
  );
  press_pulse #(.WIDTH(`PRESS_W)) u_press (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .press({select_press, load_switch_press, load_display_press,
            mem_display_press, mem_store_press}),
    .pulse(pls)
  );
  assign {sw, sw_bank, sw_sel, inc_en, dec_en, rbk_en, sbk_en} = lvl;
  assign {sel_p, lsw_p, ldisp_p, mdisp_p, mstore_p} = pls;

  // =====================================
  // helper functions
  // step pointer; both enables together leave it alone
  function automatic logic [15:0] step_ptr(input logic [15:0] p, input logic inc,
                                           input logic dec);
    logic [15:0] q;
    q = p;
    if (inc && !dec) begin
      q = 16'(p + `STEP_SIZE);
    end else if (dec && !inc) begin
      q = 16'(p - `STEP_SIZE);
    end
    return q;
  endfunction
  // one-hot selection lamp for a view
  function automatic logic [16:0] lamp_of(input view_type v);
    logic [16:0] l;
    l = '0;
    l[v] = 1'b1;
    return l;
  endfunction

  // =====================================
  // breakpoint comparators
  // read data match
  assign rd_match = rbk_en && mon_rd_valid && (mon_rd_data == sw);
  assign wr_match = sbk_en && mon_wr_valid && (mon_wr_data == sw) && (mon_wr_module == sw_bank);
  // presses that use memory are refused while a read is pending
  assign step_ok = (r.mst == idle_st);
  assign bkpt_lamp_cause = cpu_halted && r.bkpt_cause;

  // =====================================
  // next state
  always_comb begin
    next_r = r;
    next_r.halt_req = 1'b0;
    next_r.reg_wr = 1'b0;
    next_r.rd_req = 1'b0;
    next_r.wr_req = 1'b0;
    // halt on either match; set wins over running clear
    if (rd_match || wr_match) begin
      next_r.halt_req = 1'b1;
      next_r.bkpt_cause = 1'b1;
    end else if (cpu_running) begin
      next_r.bkpt_cause = 1'b0;
    end
    // operator picks a view; codes beyond the last view are ignored
    if (sel_p && (sw_sel < 5'(`VIEW_COUNT))) begin
      next_r.view = view_type'(sw_sel);
    end
    if (lsw_p) begin
      case (r.view)
        address_view: begin
          next_r.ptr = sw;
          next_r.abs_bank = sw_bank;
        end
        mem_data_view: begin
          next_r.mem_data = sw;
        end
        program_base_view: begin
          next_r.prog_bank = sw_bank;
        end
        z_view: begin
          next_r.stk_bank = sw_bank;
        end
        data_base_view: begin
          next_r.dat_bank = sw_bank;
        end
        default: begin
        end
      endcase
      // registers held in the CPU get a write pulse
      if (r.view != address_view && r.view != mem_data_view) begin
        next_r.reg_wr = 1'b1;
        next_r.reg_wr_view = r.view;
        next_r.reg_wr_data = sw;
      end
    end else if (ldisp_p) begin
      // pointer and bank from display lamps
      next_r.ptr = r.disp_word;
      next_r.abs_bank = r.disp_bank;
    end else if (mdisp_p && step_ok) begin
      next_r.view = mem_data_view;
      next_r.rd_req = 1'b1;
      next_r.addr = {r.abs_bank, r.ptr};
      next_r.mst = wait_read_st;
      next_r.ptr = step_ptr(r.ptr, inc_en, dec_en);
    end else if (mstore_p && step_ok) begin
      next_r.wr_req = 1'b1;
      next_r.addr = {r.abs_bank, r.ptr};
      next_r.wr_data = sw;
      next_r.ptr = step_ptr(r.ptr, inc_en, dec_en);
    end
    // memory display sequencer
    case (r.mst)
      idle_st: begin
      end
      wait_read_st: begin
        if (mem_rvalid) begin
          next_r.mem_data = mem_rdata;
          next_r.mst = idle_st;
        end
      end
      default: begin
        next_r.mst = idle_st;
      end
    endcase
    // display multiplexer, one cycle behind the view
    next_r.disp_bank = `BANK_RST;
    case (r.view)
      address_view: begin
        next_r.disp_word = r.ptr;
        next_r.disp_bank = r.abs_bank;
      end
      mem_data_view: begin
        next_r.disp_word = r.mem_data;
      end
      program_base_view, p_view, pl_view: begin
        next_r.disp_word = cpu_reg_data;
        next_r.disp_bank = r.prog_bank;
      end
      data_base_view: begin
        next_r.disp_word = cpu_reg_data;
        next_r.disp_bank = r.dat_bank;
      end
      dl_view, q_view, s_view, z_view: begin
        next_r.disp_word = cpu_reg_data;
        next_r.disp_bank = r.stk_bank;
      end
      default: begin
        next_r.disp_word = cpu_reg_data;
      end
    endcase
    next_r.lamps = lamp_of(next_r.view);
    next_r.bkpt_lamp = bkpt_lamp_cause;
    next_r.sys_lamp = cpu_halted && cpu_error_halt;
    next_r.run_lamp = cpu_running;
  end

  // =====================================
  // state register, frozen while ce low
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      r <= '0;
      r.lamps <= `LAMPS_RST;
    end else if (ce) begin
      r <= next_r;
    end
  end

  // =====================================
  // outputs, all from flip-flops
  assign select_lamps = r.lamps;
  assign display_word = r.disp_word;
  assign display_bank = r.disp_bank;
  assign breakpoint_halt_indicator = r.bkpt_lamp;
  assign system_halt_indicator = r.sys_lamp;
  assign run_indicator = r.run_lamp;
  assign display_view = r.view;
  assign cpu_halt_req = r.halt_req;
  assign reg_wr = r.reg_wr;
  assign reg_wr_view = r.reg_wr_view;
  assign reg_wr_data = r.reg_wr_data;
  assign program_bank = r.prog_bank;
  assign stack_bank = r.stk_bank;
  assign data_bank = r.dat_bank;
  assign mem_rd_req = r.rd_req;
  assign mem_wr_req = r.wr_req;
  assign mem_addr = r.addr;
  assign mem_wr_data = r.wr_data;

  // =====================================
  // checks
  // store breakpoint halt
  property p_store_bkpt;
    @(posedge clk_sys) disable iff (!nrst) (ce && wr_match) |=> (cpu_halt_req && r.bkpt_cause);
  endproperty
  a_store_bkpt: assert property (p_store_bkpt) else $error("store match gave no halt");
  property p_read_bkpt;
    @(posedge clk_sys) disable iff (!nrst) (ce && rd_match) |=> cpu_halt_req;
  endproperty
  a_read_bkpt: assert property (p_read_bkpt) else $error("read match gave no halt");
  property p_bkpt_lamp;
    @(posedge clk_sys) disable iff (!nrst)
      ce |=> (breakpoint_halt_indicator == $past(bkpt_lamp_cause));
  endproperty
  a_bkpt_lamp: assert property (p_bkpt_lamp) else $error("breakpoint lamp wrong");
  property p_sys_lamp;
    @(posedge clk_sys) disable iff (!nrst)
      (ce && cpu_halted && cpu_error_halt) |=> system_halt_indicator;
  endproperty
  a_sys_lamp: assert property (p_sys_lamp) else $error("system halt lamp dark");
  property p_run_lamp;
    @(posedge clk_sys) disable iff (!nrst) ce |=> (run_indicator == $past(cpu_running));
  endproperty
  a_run_lamp: assert property (p_run_lamp) else $error("run lamp wrong");
  property p_mdata_sel;
    @(posedge clk_sys) disable iff (!nrst)
      (ce && mdisp_p && step_ok && !lsw_p && !ldisp_p) |=> (select_lamps == 17'h00002);
  endproperty
  a_mdata_sel: assert property (p_mdata_sel) else $error("memory data lamp not alone");
  property p_incr;
    @(posedge clk_sys) disable iff (!nrst)
      (ce && mdisp_p && step_ok && !lsw_p && !ldisp_p && inc_en && !dec_en)
      |=> (r.ptr == 16'($past(r.ptr) + 16'h0001));
  endproperty
  a_incr: assert property (p_incr) else $error("pointer not incremented");
  property p_decr;
    @(posedge clk_sys) disable iff (!nrst)
      (ce && mstore_p && !mdisp_p && step_ok && !lsw_p && !ldisp_p && dec_en && !inc_en)
      |=> (r.ptr == 16'($past(r.ptr) - 16'h0001));
  endproperty
  a_decr: assert property (p_decr) else $error("pointer not decremented");
  property p_bank_kept;
    @(posedge clk_sys) disable iff (!nrst)
      (ce && (mdisp_p || mstore_p) && step_ok && !lsw_p && !ldisp_p) |=> $stable(r.abs_bank);
  endproperty
  a_bank_kept: assert property (p_bank_kept) else $error("step touched absolute bank");
  property p_load_disp;
    @(posedge clk_sys) disable iff (!nrst)
      (ce && ldisp_p && !lsw_p) |=> (r.ptr == $past(display_word));
  endproperty
  a_load_disp: assert property (p_load_disp) else $error("pointer not loaded");
  // dark bank lamps on memory word
  property p_dark_bank;
    @(posedge clk_sys) disable iff (!nrst)
      (ce && r.view == mem_data_view) |=> (display_bank == 2'h0);
  endproperty
  a_dark_bank: assert property (p_dark_bank) else $error("bank lamps lit for memory");
  // main scenarios
  c_mem_read: cover property (@(posedge clk_sys) mem_rd_req ##[1:20] mem_rvalid);
  c_bkpt: cover property (@(posedge clk_sys) cpu_halt_req ##[1:20] breakpoint_halt_indicator);
  c_reg_load: cover property (@(posedge clk_sys) disable iff (!nrst) reg_wr);
endmodule // maintenance_panel_control

// [test/panel_operator.sv]
`timescale 1ns/10ps
// =====================================
// operator at the switches: levels settle before any press
module panel_operator (
  // clock
  input wire logic clk_sys,
  // level switches
  output logic [15:0] switch_word,
  output logic bank_switch_bit_lo,
  output logic bank_switch_bit_hi,
  output logic [4:0] select_code,
  output logic incr_enable,
  output logic decr_enable,
  output logic read_bkpt_enable,
  output logic store_bkpt_enable,
  // presses: select, load sw, load display, mem display, mem store
  output logic [4:0] press_v
);
  // all switches at rest at time zero
  initial begin
    switch_word = 16'h0000;
    {bank_switch_bit_hi, bank_switch_bit_lo} = 2'h0;
    select_code = 5'h00;
    {incr_enable, decr_enable} = 2'h0;
    {read_bkpt_enable, store_bkpt_enable} = 2'h0;
    press_v = 5'h00;
  end
  // wait some edges
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // levels need two stable edges before a press is seen
  task automatic set_sw(input logic [15:0] w, input logic [1:0] b);
    @(posedge clk_sys);
    switch_word <= w;
    {bank_switch_bit_hi, bank_switch_bit_lo} <= b;
    idle(4);
  endtask
  task automatic set_step(input logic inc, input logic dec);
    @(posedge clk_sys);
    incr_enable <= inc & ~dec;
    decr_enable <= dec;
    idle(4);
  endtask
  // breakpoint enables
  task automatic set_bkpt(input logic r, input logic s);
    @(posedge clk_sys);
    read_bkpt_enable <= r;
    store_bkpt_enable <= s;
    idle(4);
  endtask
  // hold a press, release it, then leave room for the resync
  task automatic press(input int idx, input int hold);
    @(posedge clk_sys);
    press_v <= press_v | (5'h01 << idx);
    idle(hold);
    press_v <= press_v & ~(5'h01 << idx);
    idle(8);
  endtask
  // pick a view: code first, then the select press
  task automatic set_view(input logic [4:0] v);
    @(posedge clk_sys);
    select_code <= v;
    idle(4);
    press(0, 4);
  endtask
endmodule // panel_operator

// [test/maintenance_panel_control_test.sv]
`timescale 1ns/10ps
module maintenance_panel_control_test;
  import panel_pkg::*;
  // =====================================
  // signals
  logic clk_sys, nrst, ce, cpu_running, cpu_halted, cpu_error_halt;
  logic [15:0] cpu_reg_data, mem_rdata, mon_rd_data, mon_wr_data, switch_word;
  logic mem_rvalid, mon_rd_valid, mon_wr_valid, bank_lo, bank_hi, inc_en, dec_en;
  logic rbk_en, sbk_en;
  logic [1:0] mon_wr_module, program_bank, stack_bank, data_bank, display_bank;
  logic [4:0] select_code, press_v, display_view, reg_wr_view;
  logic [16:0] select_lamps;
  logic [15:0] display_word, reg_wr_data, mem_wr_data;
  logic bkpt_lamp, sys_lamp, run_lamp, cpu_halt_req, reg_wr, mem_rd_req, mem_wr_req;
  logic [17:0] mem_addr;
  // pulse counters and last seen request fields
  int rd_cnt = 0, wr_cnt = 0, halt_cnt = 0, regw_cnt = 0;
  logic [17:0] last_raddr, last_waddr;
  logic [15:0] last_wdata, last_regdata;
  logic [4:0] last_view;
  int err_total = 0, cmp_count = 0;
  // =====================================
  // clock, reset and fixed cpu inputs
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    {cpu_running, cpu_halted, cpu_error_halt} = 3'h0;
    cpu_reg_data = 16'h2468;
    {mon_rd_valid, mon_wr_valid} = 2'h0;
    mon_rd_data = 16'h0000;
    mon_wr_data = 16'h0000;
    mon_wr_module = 2'h0;
  end
  // =====================================
  // memory answers one cycle after a read; idle data keeps toggling
  always @(posedge clk_sys) begin
    mem_rvalid <= mem_rd_req;
    mem_rdata <= mem_rd_req ? (mem_addr[15:0] ^ 16'hA5A5) : ~mem_rdata;
    if (mem_rd_req) begin
      rd_cnt <= rd_cnt + 1;
      last_raddr <= mem_addr;
    end
    if (mem_wr_req) begin
      wr_cnt <= wr_cnt + 1;
      last_waddr <= mem_addr;
      last_wdata <= mem_wr_data;
    end
    if (reg_wr) begin
      regw_cnt <= regw_cnt + 1;
      last_view <= reg_wr_view;
      last_regdata <= reg_wr_data;
    end
    if (cpu_halt_req) halt_cnt <= halt_cnt + 1;
  end
  initial mem_rvalid = 1'b0;
  initial mem_rdata = 16'h0000;
  // =====================================
  // instances
  panel_operator op_u (.clk_sys(clk_sys), .switch_word(switch_word),
    .bank_switch_bit_lo(bank_lo), .bank_switch_bit_hi(bank_hi), .select_code(select_code),
    .incr_enable(inc_en), .decr_enable(dec_en), .read_bkpt_enable(rbk_en),
    .store_bkpt_enable(sbk_en), .press_v(press_v));
  maintenance_panel_control dut_u (.clk_sys(clk_sys), .nrst(nrst), .ce(ce),
    .switch_word(switch_word), .bank_switch_bit_lo(bank_lo), .bank_switch_bit_hi(bank_hi),
    .select_code(select_code), .select_press(press_v[0]), .load_switch_press(press_v[1]),
    .load_display_press(press_v[2]), .mem_display_press(press_v[3]),
    .mem_store_press(press_v[4]), .incr_enable(inc_en), .decr_enable(dec_en),
    .read_bkpt_enable(rbk_en), .store_bkpt_enable(sbk_en), .select_lamps(select_lamps),
    .display_word(display_word), .display_bank(display_bank),
    .breakpoint_halt_indicator(bkpt_lamp), .system_halt_indicator(sys_lamp),
    .run_indicator(run_lamp), .cpu_running(cpu_running), .cpu_halted(cpu_halted),
    .cpu_error_halt(cpu_error_halt), .cpu_reg_data(cpu_reg_data),
    .display_view(display_view), .cpu_halt_req(cpu_halt_req), .reg_wr(reg_wr),
    .reg_wr_view(reg_wr_view), .reg_wr_data(reg_wr_data), .program_bank(program_bank),
    .stack_bank(stack_bank), .data_bank(data_bank), .mem_rd_req(mem_rd_req),
    .mem_wr_req(mem_wr_req), .mem_addr(mem_addr), .mem_wr_data(mem_wr_data),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .mon_rd_valid(mon_rd_valid),
    .mon_rd_data(mon_rd_data), .mon_wr_valid(mon_wr_valid), .mon_wr_data(mon_wr_data),
    .mon_wr_module(mon_wr_module));
  // =====================================
  // compare and report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // one cycle of observed cpu memory traffic, then data moves away
  task automatic mon(input logic rd, input logic wr, input logic [15:0] d, input logic [1:0] m);
    @(posedge clk_sys);
    mon_rd_valid <= rd;
    mon_wr_valid <= wr;
    mon_rd_data <= d;
    mon_wr_data <= d;
    mon_wr_module <= m;
    @(posedge clk_sys);
    {mon_rd_valid, mon_wr_valid} <= 2'h0;
    mon_rd_data <= ~d;
    mon_wr_data <= ~d;
    repeat (3) @(posedge clk_sys);
  endtask
  // =====================================
  // scenarios
  // switch word and bank pair into the address view
  task automatic t_load_addr();
    check(select_lamps, 17'h00001);
    op_u.set_sw(16'hFFFF, 2'h2);
    op_u.press(1, 4);
    check(display_word, 16'hFFFF);
    check(display_bank, 2'h2);
  endtask
  // long held display press: one read, pointer wraps, bank kept
  task automatic t_mem_display();
    int r0;
    r0 = rd_cnt;
    op_u.set_step(1'b1, 1'b0);
    op_u.press(3, 20);
    check(rd_cnt - r0, 1);
    check(last_raddr, 18'h2FFFF);
    check(select_lamps, 17'h00002);
    check(display_view, 5'h01);
    check(display_word, 16'hFFFF ^ 16'hA5A5);
    check(display_bank, 2'h0);
    op_u.set_view(5'h00);
    check(display_word, 16'h0000);
    check(display_bank, 2'h2);
  endtask
  // store with decrement: borrow out of the pointer leaves the bank
  task automatic t_mem_store();
    int w0;
    w0 = wr_cnt;
    op_u.set_step(1'b0, 1'b1);
    op_u.set_sw(16'h1357, 2'h0);
    op_u.press(4, 4);
    check(wr_cnt - w0, 1);
    check(last_waddr, 18'h20000);
    check(last_wdata, 16'h1357);
    check(display_word, 16'hFFFF);
    check(display_bank, 2'h2);
  endtask
  // bank loads by view; a plain register view leaves all banks alone
  task automatic t_banks();
    logic [4:0] vs [4];
    logic [1:0] pb, sb, db, b;
    int c0;
    vs = '{5'h09, 5'h10, 5'h0D, 5'h05};
    {pb, sb, db} = 6'h00;
    for (int i = 0; i < 4; i++) begin
      b = (i == 3) ? 2'h3 : 2'(i + 1);
      op_u.set_sw(16'h0C30 + 16'(i), b);
      op_u.set_view(vs[i]);
      c0 = regw_cnt;
      op_u.press(1, 4);
      case (vs[i])
        5'h09: pb = b;
        5'h10: sb = b;
        5'h0D: db = b;
        default: ;
      endcase
      check(regw_cnt - c0, 1);
      check(last_view, vs[i]);
      check(last_regdata, 16'h0C30 + 16'(i));
      check({program_bank, stack_bank, data_bank}, {pb, sb, db});
    end
  endtask
  // load pointer and bank from what the program base view shows
  task automatic t_load_disp();
    op_u.set_view(5'h09);
    op_u.press(2, 4);
    op_u.set_view(5'h00);
    check(display_word, 16'h2468);
    check(display_bank, 2'h1);
  endtask
  // breakpoint matches, module qualifier and the three lamps
  task automatic t_bkpt();
    int h0;
    op_u.set_sw(16'h5A5A, 2'h1);
    h0 = halt_cnt;
    mon(1'b1, 1'b0, 16'h5A5A, 2'h1);
    check(halt_cnt - h0, 0);
    op_u.set_bkpt(1'b1, 1'b1);
    mon(1'b1, 1'b0, 16'h5A5B, 2'h1);
    check(halt_cnt - h0, 0);
    mon(1'b1, 1'b0, 16'h5A5A, 2'h1);
    check(halt_cnt - h0, 1);
    mon(1'b0, 1'b1, 16'h5A5A, 2'h2);
    check(halt_cnt - h0, 1);
    mon(1'b0, 1'b1, 16'h5A5A, 2'h1);
    check(halt_cnt - h0, 2);
    cpu_halted <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check({bkpt_lamp, sys_lamp, run_lamp}, 3'h4);
    cpu_error_halt <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check(sys_lamp, 1'b1);
    {cpu_halted, cpu_error_halt, cpu_running} <= 3'h1;
    repeat (3) @(posedge clk_sys);
    check({bkpt_lamp, sys_lamp, run_lamp}, 3'h1);
  endtask
  // =====================================
  // main sequence and watchdog
  initial begin
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    t_load_addr();
    t_mem_display();
    t_mem_store();
    t_banks();
    t_load_disp();
    t_bkpt();
    test_done();
  end
  // roughly eighteen times the expected run
  initial begin
    repeat (6000) @(posedge clk_sys);
    err_total++;
    test_done();
  end
endmodule // maintenance_panel_control_test
